// ---- cpsr_core_regs.sv ----
// Core pointer and status registers: stack, dual data pointer, status word
`timescale 1ns/10ps
`default_nettype none
module cpsr_core_regs
   import cpsr_pkg::*;
(
   input  wire logic                 clk_sys,
   input  wire logic                 sys_rst,
   input  wire cpsr_sfr_req_t        sfr_req,
   output logic [7:0]                sfr_rdata,
   output logic                      sfr_hit,
   input  wire cpsr_flag_upd_t       flag_upd,
   input  wire logic [7:0]           acc_value,
   input  wire cpsr_stack_op_t       stack_op,
   input  wire logic                 stack_go,
   input  wire logic [7:0]           push_data,
   input  wire logic [15:0]          pc_save,
   input  wire logic [7:0]           stack_mem_rdata,
   output cpsr_stack_mem_t           stack_mem,
   output logic                      stack_busy,
   output logic                      stack_done,
   output logic [7:0]                pop_data,
   output logic [15:0]               pc_restore,
   input  wire logic                 data_pointer_load,
   input  wire logic [15:0]          data_pointer_load_value,
   input  wire logic                 data_pointer_incr,
   output logic [15:0]               data_pointer,
   output logic [4:0]                bank_base,
   output logic                      carry_flag,
   output logic [7:0]                misc_control_one
);
   import cpsr_pkg::*;

   logic [7:0]  stack_top_pointer;
   logic [15:0] data_pointer_bank [2];
   logic [7:0]  status_word;
   logic        half_carry_flag;
   logic        signed_wrap_flag;
   logic        user_flag_zero;
   logic        user_flag_one;
   logic        bank_sel_hi;
   logic        bank_sel_lo;
   logic        parity_flag;
   logic        ptr_bank_choice;
   logic        wr_stack;
   logic        wr_dp_low;
   logic        wr_dp_high;
   logic        wr_status;
   logic        wr_misc;

   assign wr_stack   = sfr_req.wr_en && sfr_req.addr == CPSR_ADDR_STACK;
   assign wr_dp_low  = sfr_req.wr_en && sfr_req.addr == CPSR_ADDR_DP_LOW;
   assign wr_dp_high = sfr_req.wr_en && sfr_req.addr == CPSR_ADDR_DP_HIGH;
   assign wr_status  = sfr_req.wr_en && sfr_req.addr == CPSR_ADDR_STATUS;
   assign wr_misc    = sfr_req.wr_en && sfr_req.addr == CPSR_ADDR_MISC1;

   cpsr_stack_seq u_stack (
      .clk_sys           (clk_sys),
      .sys_rst           (sys_rst),
      .stack_op          (stack_op),
      .stack_go          (stack_go),
      .push_data         (push_data),
      .pc_save           (pc_save),
      .sfr_wr            (wr_stack),
      .sfr_wdata         (sfr_req.wdata),
      .mem_rdata         (stack_mem_rdata),
      .stack_top_pointer (stack_top_pointer),
      .mem_req           (stack_mem),
      .stack_busy        (stack_busy),
      .stack_done        (stack_done),
      .pop_data          (pop_data),
      .pc_restore        (pc_restore)
   );

   // Misc control: only the defined bits hold; bits 2 and 1 read zero
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         misc_control_one <= CPSR_RST_MISC1;
      end else if (wr_misc) begin
         misc_control_one <= sfr_req.wdata & CPSR_MISC1_MASK;
      end
   end
   assign ptr_bank_choice = misc_control_one[CPSR_BIT_PSEL];

   // Two physical pointers; only the chosen one ever changes
   for (genvar i = 0; i < 2; i++) begin : g_data_pointer
      logic sel;
      assign sel = (ptr_bank_choice == 1'(i));
      always_ff @(posedge clk_sys) begin
         if (sys_rst) begin
            data_pointer_bank[i] <= CPSR_RST_DATA_POINTER;
         end else if (sel) begin
            if (wr_dp_low) begin
               data_pointer_bank[i][7:0] <= sfr_req.wdata;
            end else if (wr_dp_high) begin
               data_pointer_bank[i][15:8] <= sfr_req.wdata;
            end else if (data_pointer_load) begin
               data_pointer_bank[i] <= data_pointer_load_value;
            end else if (data_pointer_incr) begin
               data_pointer_bank[i] <= data_pointer_bank[i] + 16'h0001;
            end
         end
      end
   end

   assign data_pointer = data_pointer_bank[ptr_bank_choice];

   // Carry; a software write in the same cycle loses to the execution unit
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         carry_flag <= CPSR_RST_STATUS[CPSR_BIT_CARRY];
      end else begin
         unique case (flag_upd.op)
            CPSR_FLG_ARITH, CPSR_FLG_CONLY: carry_flag <= flag_upd.carry;
            CPSR_FLG_MULDV, CPSR_FLG_CLRC:  carry_flag <= 1'b0;
            CPSR_FLG_SETC:                  carry_flag <= 1'b1;
            CPSR_FLG_NONE: begin
               if (wr_status) begin
                  carry_flag <= sfr_req.wdata[CPSR_BIT_CARRY];
               end
            end
            default: ;
         endcase
      end
   end

   // Half carry: only the add and subtract class moves it
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         half_carry_flag <= CPSR_RST_STATUS[CPSR_BIT_HALF];
      end else if (flag_upd.op == CPSR_FLG_ARITH) begin
         half_carry_flag <= flag_upd.half;
      end else if (wr_status) begin
         half_carry_flag <= sfr_req.wdata[CPSR_BIT_HALF];
      end
   end

   // Overflow: arithmetic and multiply/divide classes
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         signed_wrap_flag <= CPSR_RST_STATUS[CPSR_BIT_WRAP];
      end else if (flag_upd.op == CPSR_FLG_ARITH || flag_upd.op == CPSR_FLG_MULDV) begin
         signed_wrap_flag <= flag_upd.wrap;
      end else if (wr_status) begin
         signed_wrap_flag <= sfr_req.wdata[CPSR_BIT_WRAP];
      end
   end

   // Software-only flags; no instruction class touches them
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         user_flag_zero <= CPSR_RST_STATUS[CPSR_BIT_UF0];
         user_flag_one  <= CPSR_RST_STATUS[CPSR_BIT_UF1];
      end else if (wr_status) begin
         user_flag_zero <= sfr_req.wdata[CPSR_BIT_UF0];
         user_flag_one  <= sfr_req.wdata[CPSR_BIT_UF1];
      end
   end

   // Bank select; software only
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         bank_sel_hi <= CPSR_RST_STATUS[CPSR_BIT_BSHI];
         bank_sel_lo <= CPSR_RST_STATUS[CPSR_BIT_BSLO];
      end else if (wr_status) begin
         bank_sel_hi <= sfr_req.wdata[CPSR_BIT_BSHI];
         bank_sel_lo <= sfr_req.wdata[CPSR_BIT_BSLO];
      end
   end

   // Parity is never stored from software; it is registered from acc_value every cycle, one cycle late
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         parity_flag <= CPSR_RST_STATUS[CPSR_BIT_PAR];
      end else begin
         parity_flag <= ^acc_value;
      end
   end

   // Read-back view, assembled from the separate flag registers
   always_comb begin
      status_word = 8'h00;
      status_word[CPSR_BIT_CARRY] = carry_flag;
      status_word[CPSR_BIT_HALF]  = half_carry_flag;
      status_word[CPSR_BIT_UF0]   = user_flag_zero;
      status_word[CPSR_BIT_BSHI]  = bank_sel_hi;
      status_word[CPSR_BIT_BSLO]  = bank_sel_lo;
      status_word[CPSR_BIT_WRAP]  = signed_wrap_flag;
      status_word[CPSR_BIT_UF1]   = user_flag_one;
      status_word[CPSR_BIT_PAR]   = parity_flag;
   end

   assign bank_base = {bank_sel_hi, bank_sel_lo, 3'h0};

   always_comb begin
      sfr_hit = 1'b1;
      unique case (sfr_req.addr)
         CPSR_ADDR_STACK:   sfr_rdata = stack_top_pointer;
         CPSR_ADDR_DP_LOW:  sfr_rdata = data_pointer[7:0];
         CPSR_ADDR_DP_HIGH: sfr_rdata = data_pointer[15:8];
         CPSR_ADDR_STATUS:  sfr_rdata = status_word;
         CPSR_ADDR_MISC1:   sfr_rdata = misc_control_one;
         default: begin
            sfr_rdata = 8'h00;
            sfr_hit = 1'b0;
         end
      endcase
   end
endmodule : cpsr_core_regs
`default_nettype wire

// ---- cpsr_pkg.sv ----
// Package: addresses, field positions, resets and command types for the core pointer/status registers
package cpsr_pkg;
   localparam logic [7:0] CPSR_ADDR_STACK   = 8'h81;
   localparam logic [7:0] CPSR_ADDR_DP_LOW  = 8'h82;
   localparam logic [7:0] CPSR_ADDR_DP_HIGH = 8'h83;
   localparam logic [7:0] CPSR_ADDR_STATUS  = 8'hd0;
   localparam logic [7:0] CPSR_ADDR_MISC1   = 8'hf8;

   localparam logic [7:0]  CPSR_RST_STACK  = 8'h07;
   localparam logic [7:0]  CPSR_RST_STATUS = 8'h00;
   localparam logic [7:0]  CPSR_RST_MISC1  = 8'h00;
   localparam logic [15:0] CPSR_RST_DATA_POINTER   = 16'h0000;
   localparam logic [7:0]  CPSR_MISC1_MASK = 8'hf9;

   localparam int CPSR_BIT_CARRY = 7;
   localparam int CPSR_BIT_HALF  = 6;
   localparam int CPSR_BIT_UF0   = 5;
   localparam int CPSR_BIT_BSHI  = 4;
   localparam int CPSR_BIT_BSLO  = 3;
   localparam int CPSR_BIT_WRAP  = 2;
   localparam int CPSR_BIT_UF1   = 1;
   localparam int CPSR_BIT_PAR   = 0;
   localparam int CPSR_BIT_PSEL  = 0;

   // Flag update classes from the execution unit
   typedef enum logic [2:0] {
      CPSR_FLG_NONE  = 3'h0,
      CPSR_FLG_ARITH = 3'h1,
      CPSR_FLG_MULDV = 3'h2,
      CPSR_FLG_SETC  = 3'h3,
      CPSR_FLG_CLRC  = 3'h4,
      CPSR_FLG_CONLY = 3'h5
   } cpsr_flag_op_t;

   // Stack operations from the execution unit
   typedef enum logic [2:0] {
      CPSR_STK_NONE = 3'h0,
      CPSR_STK_PUSH = 3'h1,
      CPSR_STK_POP  = 3'h2,
      CPSR_STK_CALL = 3'h3,
      CPSR_STK_RET  = 3'h4
   } cpsr_stack_op_t;

   typedef struct packed {
      logic       wr_en;
      logic       rd_en;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cpsr_sfr_req_t;

   typedef struct packed {
      cpsr_flag_op_t op;
      logic          carry;
      logic          half;
      logic          wrap;
   } cpsr_flag_upd_t;

   typedef struct packed {
      logic [7:0] addr;
      logic       wr_en;
      logic       rd_en;
      logic [7:0] wdata;
   } cpsr_stack_mem_t;
endpackage : cpsr_pkg

// ---- cpsr_stack_seq.sv ----
// Stack pointer with push, pop, call and return memory sequencing
`timescale 1ns/10ps
`default_nettype none
module cpsr_stack_seq
   import cpsr_pkg::*;
(
   input  wire logic                 clk_sys,
   input  wire logic                 sys_rst,
   input  wire cpsr_stack_op_t       stack_op,
   input  wire logic                 stack_go,
   input  wire logic [7:0]           push_data,
   input  wire logic [15:0]          pc_save,
   input  wire logic                 sfr_wr,
   input  wire logic [7:0]           sfr_wdata,
   input  wire logic [7:0]           mem_rdata,
   output logic [7:0]                stack_top_pointer,
   output cpsr_stack_mem_t           mem_req,
   output logic                      stack_busy,
   output logic                      stack_done,
   output logic [7:0]                pop_data,
   output logic [15:0]               pc_restore
);
   typedef enum logic [3:0] {
      CPSR_SQ_IDLE  = 4'b0001,
      CPSR_SQ_SECND = 4'b0010,
      CPSR_SQ_RDLO  = 4'b0100,
      CPSR_SQ_FIN   = 4'b1000
   } cpsr_sq_state_t;

   cpsr_sq_state_t   state;
   cpsr_stack_op_t   cur_op;
   logic [7:0]       hi_hold;

   assign stack_busy = (state != CPSR_SQ_IDLE);

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state <= CPSR_SQ_IDLE;
         cur_op <= CPSR_STK_NONE;
      end else begin
         unique case (state)
            CPSR_SQ_IDLE: begin
               if (stack_go && stack_op != CPSR_STK_NONE) begin
                  cur_op <= stack_op;
                  state <= (stack_op == CPSR_STK_PUSH || stack_op == CPSR_STK_POP) ? CPSR_SQ_FIN : CPSR_SQ_SECND;
               end
            end
            CPSR_SQ_SECND: state <= (cur_op == CPSR_STK_RET) ? CPSR_SQ_RDLO : CPSR_SQ_FIN;
            CPSR_SQ_RDLO:  state <= CPSR_SQ_FIN;
            CPSR_SQ_FIN:   state <= CPSR_SQ_IDLE;
            default:       state <= CPSR_SQ_IDLE;
         endcase
      end
   end

   // Pointer moves; pre-increment on write, post-decrement on read
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         stack_top_pointer <= CPSR_RST_STACK;
      end else if (state == CPSR_SQ_IDLE && stack_go &&
                   (stack_op == CPSR_STK_PUSH || stack_op == CPSR_STK_CALL)) begin
         stack_top_pointer <= stack_top_pointer + 8'h01;
      end else if (state == CPSR_SQ_IDLE && stack_go &&
                   (stack_op == CPSR_STK_POP || stack_op == CPSR_STK_RET)) begin
         stack_top_pointer <= stack_top_pointer - 8'h01;
      end else if (state == CPSR_SQ_SECND && cur_op == CPSR_STK_CALL) begin
         stack_top_pointer <= stack_top_pointer + 8'h01;
      end else if (state == CPSR_SQ_SECND && cur_op == CPSR_STK_RET) begin
         stack_top_pointer <= stack_top_pointer - 8'h01;
      end else if (sfr_wr && state == CPSR_SQ_IDLE) begin
         stack_top_pointer <= sfr_wdata;
      end
   end

   // Memory strobes; read data returns one cycle after rd_en
   always_comb begin
      mem_req = '0;
      if (state == CPSR_SQ_IDLE && stack_go) begin
         unique case (stack_op)
            CPSR_STK_PUSH: begin
               mem_req.wr_en = 1'b1;
               mem_req.addr = stack_top_pointer + 8'h01;
               mem_req.wdata = push_data;
            end
            CPSR_STK_CALL: begin
               mem_req.wr_en = 1'b1;
               mem_req.addr = stack_top_pointer + 8'h01;
               mem_req.wdata = pc_save[7:0];
            end
            CPSR_STK_POP, CPSR_STK_RET: begin
               mem_req.rd_en = 1'b1;
               mem_req.addr = stack_top_pointer;
            end
            default: mem_req = '0;
         endcase
      end else if (state == CPSR_SQ_SECND) begin
         mem_req.addr = (cur_op == CPSR_STK_CALL) ? stack_top_pointer + 8'h01 : stack_top_pointer;
         mem_req.wr_en = (cur_op == CPSR_STK_CALL);
         mem_req.rd_en = (cur_op == CPSR_STK_RET);
         mem_req.wdata = pc_save[15:8];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pop_data <= 8'h00;
         pc_restore <= 16'h0000;
         hi_hold <= 8'h00;
      end else begin
         if (state == CPSR_SQ_FIN && cur_op == CPSR_STK_POP) pop_data <= mem_rdata;
         if (state == CPSR_SQ_SECND && cur_op == CPSR_STK_RET) hi_hold <= mem_rdata;
         if (state == CPSR_SQ_RDLO) pc_restore <= {hi_hold, mem_rdata};
      end
   end

   assign stack_done = (state == CPSR_SQ_FIN);
endmodule : cpsr_stack_seq
`default_nettype wire

// ---- cpsr_core_regs_props.sv ----
// Checker: port-level properties of the core pointer and status registers
`timescale 1ns/10ps
`default_nettype none
module cpsr_core_regs_props
   import cpsr_pkg::*;
(
   input wire logic            clk_sys,
   input wire logic            sys_rst,
   input wire cpsr_sfr_req_t   sfr_req,
   input wire logic [7:0]      sfr_rdata,
   input wire cpsr_flag_upd_t  flag_upd,
   input wire logic [7:0]      acc_value,
   input wire cpsr_stack_op_t  stack_op,
   input wire logic            stack_go,
   input wire logic [7:0]      push_data,
   input wire logic [15:0]     pc_save,
   input wire logic [7:0]      stack_mem_rdata,
   input wire cpsr_stack_mem_t stack_mem,
   input wire logic            stack_busy,
   input wire logic            stack_done,
   input wire logic [7:0]      pop_data,
   input wire logic [15:0]     data_pointer,
   input wire logic [4:0]      bank_base,
   input wire logic            carry_flag,
   input wire logic [7:0]      misc_control_one
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   wire logic go = stack_go && !stack_busy;
   property p_sp_reset;
      $past(sys_rst) && sfr_req.addr == CPSR_ADDR_STACK |-> sfr_rdata == CPSR_RST_STACK;
   endproperty
   a_sp_reset: assert property (p_sp_reset) else $error("stack pointer reset value wrong");
   property p_push;
      go && stack_op == CPSR_STK_PUSH |-> stack_mem.wr_en && stack_mem.wdata == push_data ##1 stack_done ##1 !stack_busy;
   endproperty
   a_push: assert property (p_push) else $error("push sequence wrong");
   property p_pop;
      go && stack_op == CPSR_STK_POP |-> stack_mem.rd_en ##1 stack_done ##1 pop_data == $past(stack_mem_rdata);
   endproperty
   a_pop: assert property (p_pop) else $error("pop sequence wrong");
   property p_call;
      go && stack_op == CPSR_STK_CALL |-> stack_mem.wr_en && stack_mem.wdata == pc_save[7:0]
         ##1 stack_mem.wr_en && stack_mem.addr == $past(stack_mem.addr) + 8'h01 ##1 stack_done;
   endproperty
   a_call: assert property (p_call) else $error("call save sequence wrong");
   property p_ret;
      go && stack_op == CPSR_STK_RET |-> stack_mem.rd_en
         ##1 stack_mem.rd_en && stack_mem.addr == $past(stack_mem.addr) - 8'h01 ##2 stack_done;
   endproperty
   a_ret: assert property (p_ret) else $error("return restore sequence wrong");
   property p_data_pointer_low;
      sfr_req.wr_en && sfr_req.addr == CPSR_ADDR_DP_LOW |=> data_pointer[7:0] == $past(sfr_req.wdata);
   endproperty
   a_data_pointer_low: assert property (p_data_pointer_low) else $error("pointer low byte write lost");
   property p_bank;
      sfr_req.addr == CPSR_ADDR_STATUS |-> bank_base == {sfr_rdata[4:3], 3'h0};
   endproperty
   a_bank: assert property (p_bank) else $error("bank base mismatch");
   property p_parity;
      sfr_req.addr == CPSR_ADDR_STATUS && !$past(sys_rst) |-> sfr_rdata[0] == ^$past(acc_value);
   endproperty
   a_parity: assert property (p_parity) else $error("parity flag stale");
   property p_cforce;
      flag_upd.op inside {CPSR_FLG_SETC, CPSR_FLG_CLRC, CPSR_FLG_MULDV}
         |=> carry_flag == ($past(flag_upd.op) == CPSR_FLG_SETC);
   endproperty
   a_cforce: assert property (p_cforce) else $error("forced carry wrong");
   property p_cfollow;
      flag_upd.op inside {CPSR_FLG_ARITH, CPSR_FLG_CONLY} |=> carry_flag == $past(flag_upd.carry);
   endproperty
   a_cfollow: assert property (p_cfollow) else $error("result carry wrong");
   property p_misc_gap;
      misc_control_one[2:1] == 2'h0;
   endproperty
   a_misc_gap: assert property (p_misc_gap) else $error("unused control bits set");
   c_call: cover property (go && stack_op == CPSR_STK_CALL);
   c_ret: cover property (go && stack_op == CPSR_STK_RET);
   c_sel: cover property (misc_control_one[0] && sfr_req.wr_en && sfr_req.addr == CPSR_ADDR_DP_HIGH);
endmodule : cpsr_core_regs_props
bind cpsr_core_regs cpsr_core_regs_props cpsr_core_regs_props_inst (.*);
`default_nettype wire

// ---- cpsr_stack_ram.sv ----
// Partner: internal RAM behind the stack port
`timescale 1ns/10ps
`default_nettype none
module cpsr_stack_ram
   import cpsr_pkg::*;
(
   input  wire logic            clk_sys,
   input  wire cpsr_stack_mem_t mem,
   output logic [7:0]           rdata
);
   logic [7:0] cells [256];
   initial rdata = 8'h00;
   always @(posedge clk_sys) begin
      if (mem.wr_en) cells[mem.addr] <= mem.wdata;
      // Stale data inverted so a late sample cannot pass by luck
      rdata <= mem.rd_en ? cells[mem.addr] : ~rdata;
   end
endmodule : cpsr_stack_ram
`default_nettype wire

// ---- testbench.sv ----
// Testbench: self-checking run of the core pointer and status registers
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import cpsr_pkg::*;
   logic clk_sys = 0, sys_rst = 1, stack_go = 0, stack_busy, stack_done, sfr_hit, carry_flag;
   logic data_pointer_load = 0, data_pointer_incr = 0;
   logic [7:0] sfr_rdata, acc_value = 0, push_data = 0, ram_q, pop_data, misc_control_one, d;
   logic [15:0] pc_save = 0, pc_restore, data_pointer_load_value = 0, data_pointer;
   logic [4:0] bank_base;
   // Parked on the stack pointer so the first edge after reset is watched
   cpsr_sfr_req_t sfr_req = '{1'b0, 1'b0, 8'h81, 8'h00};
   cpsr_flag_upd_t flag_upd = '{CPSR_FLG_NONE, 1'b0, 1'b0, 1'b0};
   cpsr_stack_op_t stack_op = CPSR_STK_NONE;
   cpsr_stack_mem_t stack_mem;
   int n_fail = 0, comparisons = 0, cyc = 0, sp, program_status_word, sel, k;
   int dp [2];
   int mem [256];
   logic [31:0] seed = 32'd73;
   cpsr_core_regs cpsr_core_regs_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .sfr_req(sfr_req),
      .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .flag_upd(flag_upd), .acc_value(acc_value),
      .stack_op(stack_op), .stack_go(stack_go), .push_data(push_data), .pc_save(pc_save),
      .stack_mem_rdata(ram_q), .stack_mem(stack_mem), .stack_busy(stack_busy), .stack_done(stack_done),
      .pop_data(pop_data), .pc_restore(pc_restore), .data_pointer_load(data_pointer_load),
      .data_pointer_load_value(data_pointer_load_value), .data_pointer_incr(data_pointer_incr), .data_pointer(data_pointer),
      .bank_base(bank_base), .carry_flag(carry_flag), .misc_control_one(misc_control_one));
   cpsr_stack_ram cpsr_stack_ram_inst (.clk_sys(clk_sys), .mem(stack_mem), .rdata(ram_q));
   always #12.5 clk_sys = ~clk_sys;
   // Ceiling well above the few hundred cycles the run needs
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc > 4000) begin
         n_fail++;
         test_done();
      end
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge clk_sys);
      sfr_req = '{1'b1, 1'b0, a, v};
      @(negedge clk_sys);
      sfr_req.wr_en = 0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(negedge clk_sys);
      sfr_req = '{1'b0, 1'b1, a, 8'h00};
      #5 d = sfr_rdata;
   endtask : rd
   task automatic stk(input cpsr_stack_op_t op);
      @(negedge clk_sys);
      stack_op = op;
      stack_go = 1;
      @(negedge clk_sys);
      stack_go = 0;
      stack_op = CPSR_STK_NONE;
      for (k = 0; k < 8 && stack_busy !== 1'b0; k++) @(negedge clk_sys);
      @(negedge clk_sys);
   endtask : stk
   task automatic test_done();
      $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : test_done
   initial begin
      repeat (8) @(negedge clk_sys);
      sys_rst = 0;
      rd(8'h81); chk(d, 16'h0007);
      rd(8'h82); chk(d, 0);
      rd(8'hd0); chk(d, 0);
      rd(8'hf8); chk(d, 0);
      rd(8'h80); chk({d, 7'h0, sfr_hit}, 0);
      $display("test reset done");
      dp = '{0, 0};
      for (int i = 0; i < 8; i++) begin
         sel = i % 2;
         wr(8'hf8, 8'(rnd()) & 8'hfe | 8'(sel));
         d = 8'(rnd());
         wr(8'h82 + 8'(i / 2 % 2), d);
         dp[sel] = (i / 2 % 2) ? (dp[sel] & 255) | (int'(d) << 8) : (dp[sel] & 16'hff00) | int'(d);
         chk(data_pointer, 16'(dp[sel]));
         wr(8'hf8, 8'(1 - sel));
         chk(data_pointer, 16'(dp[1 - sel]));
      end
      wr(8'hf8, 8'hff); rd(8'hf8); chk(d, 16'h00f9);
      @(negedge clk_sys); data_pointer_incr = 1; @(negedge clk_sys); data_pointer_incr = 0;
      chk(data_pointer, 16'(dp[1] + 1));
      data_pointer_load_value = 16'(rnd()); data_pointer_load = 1; @(negedge clk_sys); data_pointer_load = 0;
      dp[1] = int'(data_pointer_load_value);
      chk(data_pointer, data_pointer_load_value);
      wr(8'hf8, 8'h00); chk(data_pointer, 16'(dp[0]));
      $display("test pointers done");
      for (int i = 0; i < 24; i++) begin
         program_status_word = int'(rnd() & 32'hfe);
         wr(8'hd0, 8'(program_status_word));
         acc_value = 8'(rnd());
         flag_upd = '{cpsr_flag_op_t'(i % 6), 1'(rnd()), 1'(rnd()), 1'(rnd())};
         case (i % 6)
            1: program_status_word = program_status_word & 8'h3b | flag_upd.carry << 7 | flag_upd.half << 6 | flag_upd.wrap << 2;
            2: program_status_word = program_status_word & 8'h7b | flag_upd.wrap << 2;
            3: program_status_word = program_status_word | 8'h80;
            4: program_status_word = program_status_word & 8'h7f;
            5: program_status_word = program_status_word & 8'h7f | flag_upd.carry << 7;
            default: ;
         endcase
         @(negedge clk_sys); flag_upd.op = CPSR_FLG_NONE;
         rd(8'hd0); chk(d, 16'(program_status_word | ^acc_value));
         chk(bank_base, 16'(program_status_word & 8'h18));
      end
      $display("test status done");
      for (int i = 0; i < 6; i++) begin
         sp = int'(rnd() & 32'h7f);
         wr(8'h81, 8'(sp));
         push_data = 8'(rnd()); pc_save = 16'(rnd());
         stk(CPSR_STK_PUSH); sp = (sp + 1) % 256; mem[sp] = push_data;
         rd(8'h81); chk(d, 16'(sp));
         stk(CPSR_STK_CALL); mem[(sp + 1) % 256] = pc_save[7:0]; mem[(sp + 2) % 256] = pc_save[15:8];
         sp = (sp + 2) % 256;
         stk(CPSR_STK_RET); chk(pc_restore, 16'(mem[sp] << 8 | mem[(sp + 255) % 256]));
         sp = (sp + 254) % 256;
         stk(CPSR_STK_POP); chk(pop_data, 16'(mem[sp]));
         sp = (sp + 255) % 256;
         rd(8'h81); chk(d, 16'(sp));
      end
      $display("test stack done");
      test_done();
   end
endmodule : testbench
`default_nettype wire
